// file: ppcr_fault_timer.sv
// millisecond fault timer with a programmable limit and a single expiry pulse
`timescale 1ns/1ps
`default_nettype none

module ppcr_fault_timer (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_tick,
  input  wire logic                      i_run,
  input  wire logic                      i_clear,
  input  wire logic [ppcr_pkg::MS_W-1:0] i_limit,
  output logic                           o_expire
);

  logic [ppcr_pkg::MS_W-1:0] cnt_ff;
  logic                      done_ff;
  logic                      at_limit;

  assign at_limit = (cnt_ff >= i_limit);

  // count whole milliseconds while the condition lasts
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_ff <= '0;
    else if (i_clear || !i_run)
      cnt_ff <= '0;
    else if (i_tick && !at_limit)
      cnt_ff <= cnt_ff + 1'b1;
  end

  // expiry fires once per episode
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      done_ff  <= 1'b0;
      o_expire <= 1'b0;
    end
    else
    begin
      done_ff  <= i_run && !i_clear && (done_ff || at_limit);
      o_expire <= i_run && !i_clear && !done_ff && at_limit;
    end
  end

  chk_expire_single : assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) o_expire |=> !o_expire)
    else $error("fault timer expiry lasted more than one cycle");

  chk_expire_cause : assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n) o_expire |-> $past(at_limit && i_run))
    else $error("fault timer expired before its limit");

endmodule

`default_nettype wire

// file: ppcr_host_model.sv
// host model: drives the register port strobes of the serial interface
`timescale 1ns/1ps
`default_nettype none

module ppcr_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // idle state of the port at time zero
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'hFF;
    o_wdata = 8'h00;
  end

  // one write strobe, taken at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) #1;
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(posedge i_sys_clk) #1;
    o_wr_en = 1'b0;
    o_wdata = ~d; // stale data inverted so it is never mistaken
  endtask

  // one read strobe; the registered answer is taken after the edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk) #1;
    o_addr  = a;
    o_rd_en = 1'b1;
    @(posedge i_sys_clk) #1;
    o_rd_en = 1'b0;
    d       = i_rdata;
  endtask
endmodule
`default_nettype wire

// file: ppcr_pkg.sv
// package: offsets, reset values, fields and fault timing of the port bank
package ppcr_pkg;

  localparam int NPORT  = 4;
  localparam int HI_LSB = 4;              // upper nibble holds the second set

  // register offsets
  localparam logic [7:0] OFS_DROP_EN  = 8'h13;
  localparam logic [7:0] OFS_SC_EN    = 8'h14;
  localparam logic [7:0] OFS_PRIO     = 8'h15;
  localparam logic [7:0] OFS_TIMING   = 8'h16;
  localparam logic [7:0] OFS_MISC     = 8'h17;
  localparam logic [7:0] OFS_PUSH_SC  = 8'h18;
  localparam logic [7:0] OFS_PUSH_PWR = 8'h19;

  // reset values
  localparam logic [7:0] RST_DROP_EN = 8'h0F;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_MISC    = 8'h80;

  // option bit positions
  localparam int MISC_IRQ_OFF   = 7;
  localparam int MISC_CAP_OFF   = 6;
  localparam int MISC_WIDE_PRIO = 4;
  localparam int MISC_CLASS_CHG = 3;
  localparam int MISC_SENSE_CHG = 2;

  // timing field positions, two bits each
  localparam int TIM_OC_LSB    = 6;
  localparam int TIM_START_LSB = 4;
  localparam int TIM_OVLD_LSB  = 2;
  localparam int TIM_DROP_LSB  = 0;

  // per-port operating modes
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_MANUAL   = 2'h1,
    MODE_HOST     = 2'h2,
    MODE_AUTO     = 2'h3
  } ppcr_mode_t;

  // fault times in milliseconds
  localparam int         MS_W     = 10;
  localparam logic [9:0] T_6_MS   = 10'h006;
  localparam logic [9:0] T_10_MS  = 10'h00A;
  localparam logic [9:0] T_15_MS  = 10'h00F;
  localparam logic [9:0] T_30_MS  = 10'h01E;
  localparam logic [9:0] T_60_MS  = 10'h03C;
  localparam logic [9:0] T_90_MS  = 10'h05A;
  localparam logic [9:0] T_120_MS = 10'h078;
  localparam logic [9:0] T_180_MS = 10'h0B4;
  localparam logic [9:0] T_240_MS = 10'h0F0;
  localparam logic [9:0] T_360_MS = 10'h168;
  localparam logic [9:0] T_720_MS = 10'h2D0;

  // clock rate and the millisecond tick derived from it
  localparam int CLK_HZ    = 20000000;
  localparam int MS_PER_S  = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TICK_W    = 16;

endpackage

// file: ppcr_port_control_regs.sv
// port control register bank: enables, priorities, timing, push buttons
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - drop enable 1 allows low-current disconnect; 0 keeps port powered
// - overcurrent and overload cut still remove power without drop enable
// - enable register: classify bits 7-4, sense bits 3-0; 11 runs continuous
// - enables clear on shutdown, power-off, port clear, shed, group clear
// - in manual mode, enable register writes act as push sense/classify
// - single-bit priority: priority bit 1 ports shut down on shed event
// - shed input rising with a port selected raises shed event; affected ports get power-off
// - group clear clears the shed priority bits
// - cut inhibit 1 keeps power on overload; other faults still cut
// - overload still reported as event even while cut is inhibited
// - overcurrent time: 00=60, 01=15, 10=10, 11=6 ms
// - start fault time: 00=60, 01=30, 10=120 ms; limiting port cut
// - overload time: 60, 30, 120, 240 ms; over-limit port cut
// - drop delay: 360, 90, 180, 720 ms; low-current port disconnected
// - misc bit 6: 0 enables load capacitance measure, 1 disables
// - misc bit 4: 0 single-bit priority, 1 multibit priority
// - misc bit 3: 1 reports classify complete only on change
// - misc bit 2: 1 reports sense complete only on change
// - push sense/classify: classify 7-4, sense 3-0, write-only kicks
// - push sense/classify in host or auto mode copies into enables
// - push power: off bits 7-4, on bits 3-0; 1 acts, 0 nothing
// - mode 00 shutdown, 01 manual, 10 host managed, 11 automatic
// - power-off, port clear, shed and shutdown return port to defaults
module ppcr_port_control_regs #(
  parameter int P_MS_TICK_CYCLES = ppcr_pkg::MS_CYCLES
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_port_operating_select,
  input  wire logic [3:0] i_port_register_clear,
  input  wire logic       i_group_register_clear,
  input  wire logic       i_emergency_shed_input,
  input  wire logic [3:0] i_port_wide_priority_shed,
  input  wire logic [3:0] i_overcurrent,
  input  wire logic [3:0] i_start_limiting,
  input  wire logic [3:0] i_overload,
  input  wire logic [3:0] i_low_current,
  input  wire logic [3:0] i_power_good,
  output logic      [7:0] o_rdata,
  output logic      [3:0] o_port_low_current_drop_en,
  output logic      [3:0] o_port_sense_check_en,
  output logic      [3:0] o_port_classify_en,
  output logic      [3:0] o_port_sense_kick,
  output logic      [3:0] o_port_classify_kick,
  output logic      [3:0] o_port_push_power_on,
  output logic      [3:0] o_port_push_power_off,
  output logic      [3:0] o_port_clear,
  output logic            o_emergency_shed_event,
  output logic      [3:0] o_port_power_cut,
  output logic      [3:0] o_port_overload_flag,
  output logic            o_irq_drive_off,
  output logic            o_cap_measure_inhibit,
  output logic            o_wide_priority_sel,
  output logic            o_class_change_only,
  output logic            o_sense_change_only
);

  localparam int NP = ppcr_pkg::NPORT;
  localparam int HL = ppcr_pkg::HI_LSB;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]                      drop_en_ff;
  logic [7:0]                      sc_en_ff;
  logic [7:0]                      prio_ff;
  logic [7:0]                      tim_ff;
  logic [7:0]                      misc_ff;
  logic [7:0]                      kick_ff;
  logic [3:0]                      pwr_on_ff;
  logic [3:0]                      pwr_off_ff;
  logic [3:0]                      clr_ff;
  logic                            shed_evt_ff;
  logic                            shed_prev_ff;
  logic [3:0]                      cut_ff;
  logic [3:0]                      ovl_flag_ff;
  logic [7:0]                      rdata_ff;
  logic [ppcr_pkg::TICK_W-1:0]     tick_cnt_ff;
  logic                            ms_tick_ff;

  // decode and per-port control terms
  logic                            wr_drop;
  logic                            wr_sc;
  logic                            wr_prio;
  logic                            wr_tim;
  logic                            wr_misc;
  logic                            wr_psc;
  logic                            wr_ppwr;
  logic [3:0]                      is_sd;
  logic [3:0]                      is_man;
  logic [3:0]                      is_ha;
  logic                            shed_rise;
  logic [3:0]                      shed_off;
  logic [3:0]                      push_off;
  logic [3:0]                      clr;
  logic [ppcr_pkg::MS_W-1:0]       oc_ms;
  logic [ppcr_pkg::MS_W-1:0]       st_ms;
  logic [ppcr_pkg::MS_W-1:0]       ov_ms;
  logic [ppcr_pkg::MS_W-1:0]       dr_ms;
  logic [3:0]                      oc_exp;
  logic [3:0]                      st_exp;
  logic [3:0]                      ov_exp;
  logic [3:0]                      dr_exp;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_drop = i_wr_en && (i_addr == ppcr_pkg::OFS_DROP_EN);
  assign wr_sc   = i_wr_en && (i_addr == ppcr_pkg::OFS_SC_EN);
  assign wr_prio = i_wr_en && (i_addr == ppcr_pkg::OFS_PRIO);
  assign wr_tim  = i_wr_en && (i_addr == ppcr_pkg::OFS_TIMING);
  assign wr_misc = i_wr_en && (i_addr == ppcr_pkg::OFS_MISC);
  assign wr_psc  = i_wr_en && (i_addr == ppcr_pkg::OFS_PUSH_SC);
  assign wr_ppwr = i_wr_en && (i_addr == ppcr_pkg::OFS_PUSH_PWR);

  // mode decode per port
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_mode
      ppcr_pkg::ppcr_mode_t md;
      assign md = ppcr_pkg::ppcr_mode_t'(i_port_operating_select[2*gp +: 2]);
      assign is_sd[gp]  = (md == ppcr_pkg::MODE_SHUTDOWN);
      assign is_man[gp] = (md == ppcr_pkg::MODE_MANUAL);
      assign is_ha[gp]  = (md == ppcr_pkg::MODE_HOST) ||
                          (md == ppcr_pkg::MODE_AUTO);
    end
  endgenerate

  // emergency shed selection and per-port clear sources
  assign shed_rise = i_emergency_shed_input && !shed_prev_ff;
  assign shed_off  = shed_rise ? (misc_ff[ppcr_pkg::MISC_WIDE_PRIO]
                                  ? i_port_wide_priority_shed
                                  : prio_ff[HL +: NP]) : 4'h0;
  assign push_off  = wr_ppwr ? i_wdata[HL +: NP] : 4'h0;
  assign clr       = is_sd | push_off | i_port_register_clear | shed_off
                   | {NP{i_group_register_clear}};

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick for the fault timers
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tick_cnt_ff <= '0;
      ms_tick_ff  <= 1'b0;
    end
    else if (tick_cnt_ff == ppcr_pkg::TICK_W'(P_MS_TICK_CYCLES - 1))
    begin
      tick_cnt_ff <= '0;
      ms_tick_ff  <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      ms_tick_ff  <= 1'b0;
    end
  end

  // drop enable, whole-bank reset only
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      drop_en_ff <= ppcr_pkg::RST_DROP_EN;
    else if (i_group_register_clear)
      drop_en_ff <= ppcr_pkg::RST_DROP_EN;
    else if (wr_drop)
      drop_en_ff <= {4'h0, i_wdata[NP-1:0]};
  end

  // sense/classify enables: cleared by port events, written in host/auto
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sc_en_ff <= ppcr_pkg::RST_ZERO;
    else
    begin
      for (int n = 0; n < NP; n++)
      begin
        if (clr[n])
        begin
          sc_en_ff[n]      <= 1'b0;
          sc_en_ff[n + HL] <= 1'b0;
        end
        else if ((wr_sc || wr_psc) && is_ha[n])
        begin
          sc_en_ff[n]      <= i_wdata[n];
          sc_en_ff[n + HL] <= i_wdata[n + HL];
        end
      end
    end
  end

  // shed priority and overload cut inhibit
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prio_ff <= ppcr_pkg::RST_ZERO;
    else if (i_group_register_clear)
      prio_ff <= ppcr_pkg::RST_ZERO;
    else if (wr_prio)
      prio_ff <= i_wdata;
  end

  // quad-wide timing and options
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tim_ff  <= ppcr_pkg::RST_ZERO;
      misc_ff <= ppcr_pkg::RST_MISC;
    end
    else if (i_group_register_clear)
    begin
      tim_ff  <= ppcr_pkg::RST_ZERO;
      misc_ff <= ppcr_pkg::RST_MISC;
    end
    else
    begin
      if (wr_tim)
        tim_ff <= i_wdata;
      if (wr_misc)
        misc_ff <= i_wdata & 8'hDC;  // bits 5, 1 and 0 unused, read zero
    end
  end

  // push and shed strobes, one cycle each, never stored; port clear lasts as long as its sources
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      kick_ff      <= ppcr_pkg::RST_ZERO;
      pwr_on_ff    <= 4'h0;
      pwr_off_ff   <= 4'h0;
      clr_ff       <= 4'h0;
      shed_evt_ff  <= 1'b0;
      shed_prev_ff <= 1'b0;
    end
    else
    begin
      kick_ff      <= (wr_sc || wr_psc) ? (i_wdata & {is_man, is_man})
                                        : ppcr_pkg::RST_ZERO;
      pwr_on_ff    <= wr_ppwr ? i_wdata[NP-1:0] : 4'h0;
      pwr_off_ff   <= push_off | shed_off;
      clr_ff       <= clr;
      shed_evt_ff  <= |shed_off;
      shed_prev_ff <= i_emergency_shed_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time selections, shared by all ports
  always_comb
  begin
    unique case (tim_ff[ppcr_pkg::TIM_OC_LSB +: 2])
      2'h0: oc_ms = ppcr_pkg::T_60_MS;
      2'h1: oc_ms = ppcr_pkg::T_15_MS;
      2'h2: oc_ms = ppcr_pkg::T_10_MS;
      2'h3: oc_ms = ppcr_pkg::T_6_MS;
    endcase
    unique case (tim_ff[ppcr_pkg::TIM_START_LSB +: 2])
      2'h0: st_ms = ppcr_pkg::T_60_MS;
      2'h1: st_ms = ppcr_pkg::T_30_MS;
      2'h2: st_ms = ppcr_pkg::T_120_MS;
      2'h3: st_ms = ppcr_pkg::T_60_MS;  // reserved code, falls back to 60
    endcase
    unique case (tim_ff[ppcr_pkg::TIM_OVLD_LSB +: 2])
      2'h0: ov_ms = ppcr_pkg::T_60_MS;
      2'h1: ov_ms = ppcr_pkg::T_30_MS;
      2'h2: ov_ms = ppcr_pkg::T_120_MS;
      2'h3: ov_ms = ppcr_pkg::T_240_MS;
    endcase
    unique case (tim_ff[ppcr_pkg::TIM_DROP_LSB +: 2])
      2'h0: dr_ms = ppcr_pkg::T_360_MS;
      2'h1: dr_ms = ppcr_pkg::T_90_MS;
      2'h2: dr_ms = ppcr_pkg::T_180_MS;
      2'h3: dr_ms = ppcr_pkg::T_720_MS;
    endcase
  end

  // four fault timers per port
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_port
      ppcr_fault_timer u_oc (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_tick    (ms_tick_ff),
        .i_run     (i_overcurrent[gp]),
        .i_clear   (clr[gp]),
        .i_limit   (oc_ms),
        .o_expire  (oc_exp[gp])
      );
      ppcr_fault_timer u_st (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_tick    (ms_tick_ff),
        .i_run     (i_start_limiting[gp]),
        .i_clear   (clr[gp]),
        .i_limit   (st_ms),
        .o_expire  (st_exp[gp])
      );
      ppcr_fault_timer u_ov (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_tick    (ms_tick_ff),
        .i_run     (i_overload[gp] && i_power_good[gp]),
        .i_clear   (clr[gp]),
        .i_limit   (ov_ms),
        .o_expire  (ov_exp[gp])
      );
      ppcr_fault_timer u_dr (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_tick    (ms_tick_ff),
        .i_run     (i_low_current[gp] && i_power_good[gp]
                    && drop_en_ff[gp]),
        .i_clear   (clr[gp]),
        .i_limit   (dr_ms),
        .o_expire  (dr_exp[gp])
      );
    end
  endgenerate

  // cut requests and overload events
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cut_ff      <= 4'h0;
      ovl_flag_ff <= 4'h0;
    end
    else
    begin
      cut_ff      <= oc_exp | st_exp | dr_exp
                   | (ov_exp & ~prio_ff[NP-1:0]);
      ovl_flag_ff <= ov_exp;
    end
  end

  // read data; push registers read as zero
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rdata_ff <= ppcr_pkg::RST_ZERO;
    else if (i_rd_en)
    begin
      unique case (i_addr)
        ppcr_pkg::OFS_DROP_EN: rdata_ff <= drop_en_ff;
        ppcr_pkg::OFS_SC_EN:   rdata_ff <= sc_en_ff;
        ppcr_pkg::OFS_PRIO:    rdata_ff <= prio_ff;
        ppcr_pkg::OFS_TIMING:  rdata_ff <= tim_ff;
        ppcr_pkg::OFS_MISC:    rdata_ff <= misc_ff;
        default:               rdata_ff <= ppcr_pkg::RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata                    = rdata_ff;
  assign o_port_low_current_drop_en = drop_en_ff[NP-1:0];
  assign o_port_sense_check_en      = sc_en_ff[NP-1:0];
  assign o_port_classify_en         = sc_en_ff[HL +: NP];
  assign o_port_sense_kick          = kick_ff[NP-1:0];
  assign o_port_classify_kick       = kick_ff[HL +: NP];
  assign o_port_push_power_on       = pwr_on_ff;
  assign o_port_push_power_off      = pwr_off_ff;
  assign o_port_clear               = clr_ff;
  assign o_emergency_shed_event     = shed_evt_ff;
  assign o_port_power_cut           = cut_ff;
  assign o_port_overload_flag       = ovl_flag_ff;
  assign o_irq_drive_off       = misc_ff[ppcr_pkg::MISC_IRQ_OFF];
  assign o_cap_measure_inhibit = misc_ff[ppcr_pkg::MISC_CAP_OFF];
  assign o_wide_priority_sel   = misc_ff[ppcr_pkg::MISC_WIDE_PRIO];
  assign o_class_change_only   = misc_ff[ppcr_pkg::MISC_CLASS_CHG];
  assign o_sense_change_only   = misc_ff[ppcr_pkg::MISC_SENSE_CHG];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_drop_gate_cut : assert property (
    o_port_power_cut[0] && !$past(drop_en_ff[0])
    |-> $past(oc_exp[0] || st_exp[0] || ov_exp[0]))
    else $error("low-current cut while drop disabled");

  chk_oc_cuts_port : assert property (
    oc_exp[0] |=> o_port_power_cut[0])
    else $error("overcurrent expiry did not cut port");

  chk_clear_enables : assert property (
    clr[1] |=> !o_port_sense_check_en[1] && !o_port_classify_en[1])
    else $error("port enables survived a clear");

  chk_manual_kick : assert property (
    wr_sc && is_man[3] && !clr[3]
    |=> o_port_sense_kick[3] == $past(i_wdata[3])
        && $stable(o_port_sense_check_en[3]))
    else $error("manual enable write not redirected");

  chk_shed_single : assert property (
    shed_rise && !o_wide_priority_sel && prio_ff[HL + 2]
    |=> o_port_push_power_off[2] && !o_port_classify_en[2])
    else $error("priority port not shed");

  chk_shed_event : assert property (
    $rose(i_emergency_shed_input) && (shed_off != 4'h0)
    |=> o_emergency_shed_event ##1 !o_emergency_shed_event)
    else $error("shed event pulse wrong");

  chk_group_prio : assert property (
    i_group_register_clear |=> prio_ff == 8'h00)
    else $error("priority bits survived group clear");

  chk_inhibit_keeps : assert property (
    ov_exp[0] && prio_ff[0] && !oc_exp[0] && !st_exp[0] && !dr_exp[0]
    |=> !o_port_power_cut[0] && o_port_overload_flag[0])
    else $error("inhibited overload cut the port");

  chk_oc_time_map : assert property (
    tim_ff[ppcr_pkg::TIM_OC_LSB +: 2] == 2'h3 |-> oc_ms == ppcr_pkg::T_6_MS)
    else $error("overcurrent time map wrong");

  chk_copy_push : assert property (
    wr_psc && is_ha[1] && !clr[1]
    |=> o_port_classify_en[1] == $past(i_wdata[5]) && !o_port_classify_kick[1])
    else $error("push write not copied in host mode");

  chk_push_strobe : assert property (
    (o_port_push_power_on != 4'h0) && !wr_ppwr
    |=> o_port_push_power_on == 4'h0)
    else $error("push strobe persisted");

  cov_shed : cover property (shed_rise && shed_off != 4'h0);
  cov_cut : cover property (o_port_power_cut != 4'h0);
  cov_manual_kick : cover property (o_port_classify_kick != 4'h0);

endmodule

`default_nettype wire

// file: ppcr_port_control_regs_bench.sv
// self-checking bench for the port control register bank
`timescale 1ns/1ps
`default_nettype none

module ppcr_port_control_regs_bench;
  localparam int TK = 4; // cycles per simulated millisecond
  logic       clk;
  logic       rst_n;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] mode;
  logic [3:0] pclr;
  logic       gclr;
  logic       shed;
  logic [3:0] oc;
  logic [3:0] ovl;
  logic [3:0] lc;
  logic [3:0] st;
  logic [3:0] de;
  logic [3:0] se;
  logic [3:0] ce;
  logic [3:0] pc;
  wire  [3:0] opt;
  logic [3:0] sk;
  logic [3:0] ck;
  logic [3:0] pon;
  logic [3:0] poff;
  logic       sev;
  logic [3:0] cut;
  logic [3:0] ovf;
  logic       irq_off;
  int         failures;
  int         samples_checked;
  int         lims [4] = '{60, 15, 10, 6};
  logic [7:0] rst_tab [8] = '{8'h0F, 8'h00, 8'h00, 8'h00,
                              8'h80, 8'h00, 8'h00, 8'h00};

  ppcr_host_model host_u (.i_sys_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  ppcr_port_control_regs #(.P_MS_TICK_CYCLES(TK)) dut_u (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .i_port_operating_select(mode),
    .i_port_register_clear(pclr), .i_group_register_clear(gclr),
    .i_emergency_shed_input(shed), .i_port_wide_priority_shed(4'h0),
    .i_overcurrent(oc), .i_start_limiting(st), .i_overload(ovl),
    .i_low_current(lc), .i_power_good(4'hF), .o_rdata(rdata),
    .o_port_low_current_drop_en(de), .o_port_sense_check_en(se),
    .o_port_classify_en(ce), .o_port_sense_kick(sk), .o_port_classify_kick(ck),
    .o_port_push_power_on(pon), .o_port_push_power_off(poff),
    .o_port_clear(pc), .o_emergency_shed_event(sev), .o_port_power_cut(cut),
    .o_port_overload_flag(ovf), .o_irq_drive_off(irq_off),
    .o_cap_measure_inhibit(opt[3]), .o_wide_priority_sel(opt[2]),
    .o_class_change_only(opt[1]), .o_sense_change_only(opt[0]));

  ////////////////////////////////////////////////////////////////////////////
  // compare, register read and fault timer helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask

  // hold one fault kind on port 0 and measure cycles until the timer reacts
  // kinds: 0 overcurrent, 1 overload, 2 low current, 3 low current no cut,
  // 4 start limiting
  task automatic tm(input int lim, input int kd);
    int   n;
    logic saw_cut;
    n       = 0;
    saw_cut = 1'b0;
    oc[0]   = (kd == 0);
    ovl[0]  = (kd == 1);
    lc[0]   = (kd == 2 || kd == 3);
    st[0]   = (kd == 4);
    while ((kd == 1 ? ovf[0] : cut[0]) !== 1'b1 && n < 1200)
    begin
      @(posedge clk) #1;
      n++;
      saw_cut = saw_cut | cut[0];
    end
    oc     = 4'h0;
    ovl    = 4'h0;
    lc     = 4'h0;
    st     = 4'h0;
    if (kd == 3)
      chk({7'h00, saw_cut}, 8'h00);
    else
      chk(8'(n >= (lim - 1) * TK + 2 && n <= lim * TK + TK + 3), 8'h01);
    if (kd == 1)
      chk({7'h00, saw_cut}, 8'h00);
    repeat (4) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock at 20 MHz
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // stop a hung run
  initial
  begin
    #500000;
    failures++;
    stop_test;
  end

  // main sequence: all ports host managed unless a test says otherwise
  initial
  begin
    failures        = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    mode  = 8'hAA;
    pclr  = 4'h0;
    gclr  = 1'b0;
    shed  = 1'b0;
    oc    = 4'h0;
    ovl   = 4'h0;
    lc    = 4'h0;
    st    = 4'h0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
      rc(i < 7 ? 8'(8'h13 + i) : 8'h20, rst_tab[i]);
    $display("test reset values done");
    host_u.wr(8'h17, 8'hFF);
    rc(8'h17, 8'hDC);
    chk({4'h0, opt}, 8'h0F);
    chk({7'h00, irq_off}, 8'h01);
    host_u.wr(8'h17, 8'h00);
    chk({7'h00, irq_off}, 8'h00);
    host_u.wr(8'h20, 8'hFF);
    rc(8'h20, 8'h00);
    $display("test options done");
    host_u.wr(8'h14, 8'h33);
    rc(8'h14, 8'h33);
    chk({ce, se}, 8'h33);
    @(posedge clk) #1 pclr = 4'h2;
    @(posedge clk) #1 pclr = 4'h0;
    chk({4'h0, pc}, 8'h02);
    rc(8'h14, 8'h11);
    $display("test enables done");
    host_u.wr(8'h19, 8'h01);
    chk({4'h0, pon}, 8'h01);
    @(posedge clk) #1;
    chk({4'h0, pon}, 8'h00);
    host_u.wr(8'h19, 8'h10);
    chk({4'h0, poff}, 8'h01);
    rc(8'h14, 8'h00);
    rc(8'h19, 8'h00);
    host_u.wr(8'h18, 8'h44);
    rc(8'h14, 8'h44);
    $display("test push buttons done");
    mode = 8'h6A;
    host_u.wr(8'h14, 8'hCC);
    chk({sk, ck}, 8'h88);
    rc(8'h14, 8'h44);
    mode = 8'hAA;
    $display("test manual port done");
    host_u.wr(8'h15, 8'h40);
    shed = 1'b1;
    @(posedge clk) #1;
    chk({3'h0, sev, poff}, 8'h14);
    shed = 1'b0;
    rc(8'h14, 8'h00);
    $display("test shed done");
    host_u.wr(8'h17, 8'h10);
    gclr = 1'b1;
    @(posedge clk) #1 gclr = 1'b0;
    @(posedge clk) #1;
    rc(8'h15, 8'h00);
    rc(8'h17, 8'h80);
    $display("test group clear done");
    host_u.wr(8'h16, 8'h01);
    tm(90, 2);
    host_u.wr(8'h13, 8'h0E);
    chk({4'h0, de}, 8'h0E);
    tm(0, 3);
    for (int c = 0; c < 4; c++)
    begin
      host_u.wr(8'h16, 8'(c << 6));
      tm(lims[c], 0);
    end
    host_u.wr(8'h16, 8'h10);
    tm(30, 4);
    host_u.wr(8'h15, 8'h01);
    host_u.wr(8'h16, 8'h04);
    tm(30, 1);
    $display("test fault timers done");
    stop_test;
  end
endmodule
`default_nettype wire
